/* verilog/iso_io.sv */
// isolated status and control i/o: relay outputs, qualified command inputs,
// board enable state and an axi4-lite register slave.
// assumes command inputs and board pins are synchronous to ref_clk.
`timescale 1ns/1ns
module iso_io #(
    parameter int HOLD_CYCLES = iso_pkg::HOLD_CYC
) (
    input  wire logic        ref_clk,
    input  wire logic        reset,
    input  wire logic [2:0]  cmd_in,
    input  wire logic        board_detect,
    input  wire logic [16:0] board_resp,
    output logic [16:0]      relay_o,
    output logic             cmd_start_o,
    output logic             cmd_shutdown_o,
    output logic             cmd_clear_o,
    output logic             charge_inhibit_o,
    output logic             local_panel_en_o,
    output logic [1:0]       board_state_o,
    output logic             board_warn_o,
    output logic [2:0]       led_in_o,
    output logic [16:0]      led_out_o,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    logic [15:0]       rpm_r;
    logic [9:0]        soc_r;
    logic [4:0]        cond_r;
    logic [2:0]        cmd_sticky_r;
    logic [2:0]        cmd_pulse_r;
    logic [2:0]        qual;
    logic [16:0]       relay_r;
    logic [16:0]       relay_nxt;
    iso_pkg::iso_brd_e brd_r;
    logic              brd_on;
    logic              mismatch;
    logic              warn_r;
    logic [1:0]        state_code_r;
    logic              panel_r;
    logic              inhibit_r;
    logic [2:0]        led_in_r;
    logic [7:0]        aw_addr_r;
    logic [31:0]       w_data_r;
    logic [3:0]        w_strb_r;
    logic              aw_full_r;
    logic              w_full_r;
    logic              bvalid_r;
    logic [1:0]        bresp_r;
    logic              rvalid_r;
    logic [31:0]       rdata_r;
    logic [1:0]        rresp_r;
    logic              wr_do;
    logic              wr_hit;
    logic              cmd_clr_wr;
    logic [31:0]       rd_val;
    logic              rd_hit;

    assign brd_on = (brd_r == iso_pkg::ISO_B_ON);
    assign mismatch = brd_on && (board_resp != relay_r);

    // board enable: the detect pin is sampled on the first edge after reset
    // software toggles are ignored until the strap has been sampled
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            brd_r <= iso_pkg::ISO_B_INIT;
        end else begin
            case (brd_r)
                iso_pkg::ISO_B_INIT: begin
                    brd_r <= board_detect ? iso_pkg::ISO_B_ON : iso_pkg::ISO_B_OFF;
                end
                iso_pkg::ISO_B_ON, iso_pkg::ISO_B_OFF: begin
                    if (wr_do && wr_hit && aw_addr_r == iso_pkg::ADDR_BOARD && w_strb_r[0]) begin
                        brd_r <= w_data_r[0] ? iso_pkg::ISO_B_ON : iso_pkg::ISO_B_OFF;
                    end
                end
                default: begin
                    brd_r <= iso_pkg::ISO_B_INIT;
                end
            endcase
        end
    end

    // command qualification: each input counts its own high time
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : gen_q
            logic [24:0] cnt_r;
            logic        fired_r;
            logic        ok;
            logic        at_end;
            // start and shutdown together cancel each other
            assign ok = brd_on && cmd_in[gi] && !(gi < 2 && cmd_in[0] && cmd_in[1]);
            assign at_end = (cnt_r == 25'(HOLD_CYCLES - 1));
            assign qual[gi] = ok && !fired_r && at_end;
            always_ff @(posedge ref_clk or posedge reset) begin
                if (reset) begin
                    cnt_r   <= '0;
                    fired_r <= 1'b0;
                end else if (!ok) begin
                    cnt_r   <= '0;
                    fired_r <= 1'b0;
                end else if (at_end) begin
                    fired_r <= 1'b1;
                end else begin
                    cnt_r <= cnt_r + 25'h0000001;
                end
            end
        end
    endgenerate

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            cmd_pulse_r <= 3'h0;
        end else begin
            cmd_pulse_r <= qual;
        end
    end

    // sticky record of issued commands, a new command beats a clear
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            cmd_sticky_r <= 3'h0;
        end else if (cmd_clr_wr) begin
            cmd_sticky_r <= (cmd_sticky_r & ~w_data_r[2:0]) | qual;
        end else begin
            cmd_sticky_r <= cmd_sticky_r | qual;
        end
    end

    // relay map
    always_comb begin
        relay_nxt = 17'h00000;
        relay_nxt[iso_pkg::OUT_OFF] = (rpm_r < iso_pkg::RPM_OFF_MAX) || cond_r[iso_pkg::COND_HOT];
        relay_nxt[iso_pkg::OUT_UP] = (rpm_r >= iso_pkg::RPM_OFF_MAX) && (rpm_r <= iso_pkg::RPM_CHG_MIN);
        relay_nxt[iso_pkg::OUT_CHG] = rpm_r > iso_pkg::RPM_CHG_MIN;
        for (int k = 0; k < 8; k++) begin
            relay_nxt[iso_pkg::OUT_SOC0 + k] = soc_r >= 10'(k * iso_pkg::SOC_STEP);
        end
        relay_nxt[iso_pkg::OUT_RDY]  = soc_r >= iso_pkg::SOC_READY;
        relay_nxt[iso_pkg::OUT_DIS]  = cond_r[iso_pkg::COND_DIS];
        relay_nxt[iso_pkg::OUT_SHD]  = cond_r[iso_pkg::COND_SHD];
        relay_nxt[iso_pkg::OUT_WRN]  = cond_r[iso_pkg::COND_WRN];
        relay_nxt[iso_pkg::OUT_FLT]  = cond_r[iso_pkg::COND_FLT];
        relay_nxt[iso_pkg::OUT_TEMP] = cond_r[iso_pkg::COND_HOT];
        if (!brd_on) begin
            relay_nxt = 17'h00000;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            relay_r <= 17'h00000;
        end else begin
            relay_r <= relay_nxt;
        end
    end

    // panel-facing state
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            warn_r       <= 1'b0;
            state_code_r <= iso_pkg::BOARD_UNAVAILABLE_CODE;
            panel_r      <= 1'b0;
            inhibit_r    <= 1'b0;
            led_in_r     <= 3'h0;
        end else begin
            warn_r    <= mismatch;
            panel_r   <= !brd_on && brd_r != iso_pkg::ISO_B_INIT;
            inhibit_r <= cond_r[iso_pkg::COND_HOT];
            led_in_r  <= cmd_in;
            if (brd_r == iso_pkg::ISO_B_INIT || mismatch) begin
                state_code_r <= iso_pkg::BOARD_UNAVAILABLE_CODE;
            end else begin
                state_code_r <= brd_on ? iso_pkg::BRD_EN_CODE : iso_pkg::BRD_DIS_CODE;
            end
        end
    end

    // axi4-lite write side: address and data may come in either order
    assign wr_do = aw_full_r && w_full_r && !bvalid_r;
    assign wr_hit = aw_addr_r == iso_pkg::ADDR_RPM || aw_addr_r == iso_pkg::ADDR_SOC ||
                    aw_addr_r == iso_pkg::ADDR_COND || aw_addr_r == iso_pkg::ADDR_BOARD ||
                    aw_addr_r == iso_pkg::ADDR_CMD || aw_addr_r == iso_pkg::ADDR_RELAY;
    assign cmd_clr_wr = wr_do && aw_addr_r == iso_pkg::ADDR_CMD && w_strb_r[0];

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            aw_full_r <= 1'b0;
            w_full_r  <= 1'b0;
            aw_addr_r <= 8'h00;
            w_data_r  <= 32'h00000000;
            w_strb_r  <= 4'h0;
            bvalid_r  <= 1'b0;
            bresp_r   <= iso_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid && !aw_full_r) begin
                aw_full_r <= 1'b1;
                aw_addr_r <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (s_axi_wvalid && !w_full_r) begin
                w_full_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (wr_do) begin
                aw_full_r <= 1'b0;
                w_full_r  <= 1'b0;
                bvalid_r  <= 1'b1;
                bresp_r   <= wr_hit ? iso_pkg::RESP_OKAY : iso_pkg::RESP_SLVERR;
            end else if (bvalid_r && s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // software-written plant state; byte lanes honoured
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            rpm_r  <= 16'h0000;
            soc_r  <= 10'h000;
            cond_r <= 5'h00;
        end else if (wr_do) begin
            if (aw_addr_r == iso_pkg::ADDR_RPM) begin
                if (w_strb_r[0]) rpm_r[7:0] <= w_data_r[7:0];
                if (w_strb_r[1]) rpm_r[15:8] <= w_data_r[15:8];
            end
            if (aw_addr_r == iso_pkg::ADDR_SOC) begin
                if (w_strb_r[0]) soc_r[7:0] <= w_data_r[7:0];
                if (w_strb_r[1]) soc_r[9:8] <= w_data_r[9:8];
            end
            if (aw_addr_r == iso_pkg::ADDR_COND && w_strb_r[0]) begin
                cond_r <= w_data_r[4:0];
            end
        end
    end

    // axi4-lite read side
    always_comb begin
        rd_val = 32'h00000000;
        rd_hit = 1'b1;
        case ({s_axi_araddr[7:2], 2'b00})
            iso_pkg::ADDR_RPM:   rd_val[15:0] = rpm_r;
            iso_pkg::ADDR_SOC:   rd_val[9:0] = soc_r;
            iso_pkg::ADDR_COND:  rd_val[4:0] = cond_r;
            iso_pkg::ADDR_BOARD: rd_val[5:0] = {board_detect, panel_r, 2'b00, state_code_r};
            iso_pkg::ADDR_CMD:   rd_val[2:0] = cmd_sticky_r;
            iso_pkg::ADDR_RELAY: rd_val[16:0] = relay_r;
            default:             rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h00000000;
            rresp_r  <= iso_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && !rvalid_r) begin
            rvalid_r <= 1'b1;
            rdata_r  <= rd_val;
            rresp_r  <= rd_hit ? iso_pkg::RESP_OKAY : iso_pkg::RESP_SLVERR;
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    assign s_axi_awready    = !aw_full_r;
    assign s_axi_wready     = !w_full_r;
    assign s_axi_bvalid     = bvalid_r;
    assign s_axi_bresp      = bresp_r;
    assign s_axi_arready    = !rvalid_r;
    assign s_axi_rvalid     = rvalid_r;
    assign s_axi_rdata      = rdata_r;
    assign s_axi_rresp      = rresp_r;
    assign relay_o          = relay_r;
    assign led_out_o        = relay_r;
    assign led_in_o         = led_in_r;
    assign cmd_start_o      = cmd_pulse_r[iso_pkg::CMD_START];
    assign cmd_shutdown_o   = cmd_pulse_r[iso_pkg::CMD_SHD];
    assign cmd_clear_o      = cmd_pulse_r[iso_pkg::CMD_CLR];
    assign charge_inhibit_o = inhibit_r;
    assign local_panel_en_o = panel_r;
    assign board_state_o    = state_code_r;
    assign board_warn_o     = warn_r;

    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);

    sequence mis_s;
        brd_on && (board_resp != relay_r);
    endsequence

    sequence hot_s;
        brd_on && cond_r[iso_pkg::COND_HOT];
    endsequence

    off_mode_a: assert property (brd_on && rpm_r < iso_pkg::RPM_OFF_MAX |=> relay_o[0])
        else $error("off output missing at low speed");
    startup_mode_a: assert property (brd_on && rpm_r >= iso_pkg::RPM_OFF_MAX &&
                                     rpm_r <= iso_pkg::RPM_CHG_MIN |=> relay_o[1])
        else $error("startup output missing");
    charge_mode_a: assert property (brd_on && rpm_r > iso_pkg::RPM_CHG_MIN |=> relay_o[2] && !relay_o[1])
        else $error("charge output wrong");
    soc_top_a: assert property (brd_on && soc_r >= 10'(7 * iso_pkg::SOC_STEP) |=> relay_o[10:3] == 8'hff)
        else $error("threshold outputs wrong");
    soc_low_a: assert property (brd_on && soc_r < iso_pkg::SOC_STEP |=> relay_o[10:4] == 7'h00)
        else $error("threshold outputs early");
    ready_mode_a: assert property (brd_on && soc_r < 10'h3de |=> !relay_o[11])
        else $error("ready output early");
    hot_rotor_a: assert property (hot_s |=> relay_o[0] && relay_o[16] && charge_inhibit_o)
        else $error("hot rotor not shown");
    // the count freezes at its end value, so a pulse proves a full hold was seen
    short_cmd_a: assert property ($rose(cmd_clear_o) |-> $past(gen_q[2].cnt_r) == 25'(HOLD_CYCLES - 1))
        else $error("clear issued before hold time");
    cmd_once_a: assert property (cmd_start_o |=> !cmd_start_o)
        else $error("start issued twice for one hold");
    both_cmd_a: assert property (cmd_in[0] && cmd_in[1] |=> !cmd_start_o && !cmd_shutdown_o)
        else $error("conflicting commands acted on");
    disabled_a: assert property (!brd_on |=> relay_o == 17'h00000 ##1 !cmd_start_o)
        else $error("disabled board drives outputs");
    panel_lock_a: assert property (brd_on |=> !local_panel_en_o)
        else $error("panel controls offered while enabled");
    resp_warn_a: assert property (mis_s |=> board_warn_o &&
                                  board_state_o == iso_pkg::BOARD_UNAVAILABLE_CODE)
        else $error("response mismatch not flagged");
    warn_clear_a: assert property (brd_on && board_resp == relay_r |=> !board_warn_o)
        else $error("warning without a mismatch");
    state_code_a: assert property (brd_on && board_resp == relay_r |=>
                                   board_state_o == iso_pkg::BRD_EN_CODE)
        else $error("enabled state code wrong");
endmodule

/* inc/iso_pkg.sv */
// constants for the isolated status and control i/o block
// assumes one 100 MHz clock and a register bus with 8-bit byte addresses
// Operation
// - off-mode output on while rotor speed is below 200 rpm.
// - startup-mode output on while rotor speed is 200 to 25000 rpm.
// - charge-mode output on while rotor speed exceeds 25000 rpm.
// - eight charge thresholds, 0% upward in 12.5% steps to 87.5%.
// - ready-mode output on once charge reaches 99%.
// - hot rotor shows off together with other outputs; charging held off.
// - command inputs must stay high 200 ms; shorter pulses are ignored.
// - start and shutdown together are both ignored.
// - qualified inputs issue start, shutdown and clear-fault commands.
// - board detected at power-up or reboot is enabled automatically.
// - board missing at power-up or reboot is disabled automatically.
// - disabled board ignores inputs and forces all relays off.
// - enabled board withholds local panel start, stop and clear-fault.
// - board state reported as 1 enabled, 0 disabled, else unavailable code.
// - board responses watched continuously; mismatch raises a warning (compared only while the board is enabled).
// - an indicator lights for each asserted input and output.
package iso_pkg;
    localparam logic [7:0] ADDR_RPM   = 8'h00;
    localparam logic [7:0] ADDR_SOC   = 8'h04;
    localparam logic [7:0] ADDR_COND  = 8'h08;
    localparam logic [7:0] ADDR_BOARD = 8'h0c;
    localparam logic [7:0] ADDR_CMD   = 8'h10;
    localparam logic [7:0] ADDR_RELAY = 8'h14;
    localparam int CLK_MHZ  = 100;
    localparam int HOLD_MS  = 200;
    localparam int HOLD_CYC = HOLD_MS * 1000 * CLK_MHZ;
    localparam logic [15:0] RPM_OFF_MAX = 16'h00c8;
    localparam logic [15:0] RPM_CHG_MIN = 16'h61a8;
    // charge is held in tenths of a percent
    localparam logic [9:0]  SOC_STEP  = 10'h07d;
    localparam logic [9:0]  SOC_READY = 10'h3de;
    localparam int COND_DIS = 0;
    localparam int COND_SHD = 1;
    localparam int COND_WRN = 2;
    localparam int COND_FLT = 3;
    localparam int COND_HOT = 4;
    localparam int OUT_OFF  = 0;
    localparam int OUT_UP   = 1;
    localparam int OUT_CHG  = 2;
    localparam int OUT_SOC0 = 3;
    localparam int OUT_RDY  = 11;
    localparam int OUT_DIS  = 12;
    localparam int OUT_SHD  = 13;
    localparam int OUT_WRN  = 14;
    localparam int OUT_FLT  = 15;
    localparam int OUT_TEMP = 16;
    localparam int CMD_START = 0;
    localparam int CMD_SHD   = 1;
    localparam int CMD_CLR   = 2;
    localparam logic [1:0] BRD_DIS_CODE = 2'h0;
    localparam logic [1:0] BRD_EN_CODE  = 2'h1;
    localparam logic [1:0] BOARD_UNAVAILABLE_CODE = 2'h3;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {ISO_B_INIT, ISO_B_ON, ISO_B_OFF} iso_brd_e;
endpackage

/* verification/iso_far_end.sv */
// far-side equipment model: drives the command inputs and the strap, reads back the contacts
// assumes a bench that calls press() right after a rising edge of ref_clk
`timescale 1ns/1ns
module iso_far_end (
    input  wire logic        ref_clk,
    input  wire logic        detect_strap,
    input  wire logic        resp_fault,
    input  wire logic [16:0] relay,
    output logic [2:0]       cmd_in,
    output logic             board_detect,
    output logic [16:0]      board_resp
);
    initial begin
        cmd_in = 3'h0;
    end
    assign board_detect = detect_strap;
    // a faulty contact flips one readback bit, so the mismatch shows whatever the relays hold
    assign board_resp = relay ^ {16'h0000, resp_fault};
    // short holds are commanded on purpose to prove they are refused
    task automatic press(input logic [2:0] mask, input int cycles);
        cmd_in <= mask;
        repeat (cycles) @(posedge ref_clk);
        cmd_in <= 3'h0;
    endtask
endmodule

/* verification/testbench.sv */
// self-checking bench for the isolated status and control i/o block
// assumes the far-side model and a shortened command hold count
`timescale 1ns/1ns
module testbench;
    localparam int HOLD = 8;
    logic        ref_clk, reset, detect_strap, resp_fault, board_detect, led_chk;
    logic [2:0]  cmd_in, led_in_o, cmd_d;
    logic [16:0] board_resp, relay_o, led_out_o;
    logic        cmd_start_o, cmd_shutdown_o, cmd_clear_o, charge_inhibit_o, local_panel_en_o, board_warn_o;
    logic [1:0]  board_state_o, s_axi_bresp, s_axi_rresp;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [31:0] exp_data_q[$];
    logic [1:0]  exp_resp_q[$];
    int          mismatches, tests_run, n_start, n_shd, n_clr;
    logic [15:0] t_rpm[6] = '{16'h00c7, 16'h00c8, 16'h61a8, 16'h61a9, 16'h0064, 16'h7530};
    logic [9:0]  t_soc[6] = '{10'h000, 10'h07c, 10'h07d, 10'h3de, 10'h3dd, 10'h3e8};
    logic [4:0]  t_cond[6] = '{5'h00, 5'h00, 5'h01, 5'h0e, 5'h10, 5'h10};

    iso_io #(.HOLD_CYCLES(HOLD)) i_dut (.ref_clk(ref_clk), .reset(reset), .cmd_in(cmd_in),
        .board_detect(board_detect), .board_resp(board_resp), .relay_o(relay_o), .cmd_start_o(cmd_start_o),
        .cmd_shutdown_o(cmd_shutdown_o), .cmd_clear_o(cmd_clear_o), .charge_inhibit_o(charge_inhibit_o),
        .local_panel_en_o(local_panel_en_o), .board_state_o(board_state_o), .board_warn_o(board_warn_o),
        .led_in_o(led_in_o), .led_out_o(led_out_o), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

    iso_far_end u_far (.ref_clk(ref_clk), .detect_strap(detect_strap), .resp_fault(resp_fault),
        .relay(relay_o), .cmd_in(cmd_in), .board_detect(board_detect), .board_resp(board_resp));

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic do_reset();
        reset <= 1'b1;
        repeat (8) @(posedge ref_clk);
        reset <= 1'b0;
        // strap decided at the first edge, state code shown one edge later
        repeat (2) @(posedge ref_clk);
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw;
        logic w;
        aw = 1'b0;
        w = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw && w)) begin
            @(posedge ref_clk);
            if (!aw && s_axi_awready) begin
                aw = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w && s_axi_wready) begin
                w = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge ref_clk); while (!s_axi_bvalid);
        check({30'h0, s_axi_bresp}, {30'h0, er});
        s_axi_bready <= 1'b0;
        @(posedge ref_clk);
    endtask

    // the monitor below pops the expectation when the data beat is handed over
    task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        exp_data_q.push_back(d);
        exp_resp_q.push_back(er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge ref_clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge ref_clk); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        @(posedge ref_clk);
    endtask

    function automatic logic [16:0] exp_relay(input logic [15:0] r, input logic [9:0] s, input logic [4:0] c);
        logic [16:0] e;
        e = 17'h00000;
        e[iso_pkg::OUT_OFF] = (r < iso_pkg::RPM_OFF_MAX) || c[iso_pkg::COND_HOT];
        e[iso_pkg::OUT_UP] = (r >= iso_pkg::RPM_OFF_MAX) && (r <= iso_pkg::RPM_CHG_MIN);
        e[iso_pkg::OUT_CHG] = r > iso_pkg::RPM_CHG_MIN;
        for (int k = 0; k < 8; k++) begin
            e[iso_pkg::OUT_SOC0 + k] = s >= 10'(k * iso_pkg::SOC_STEP);
        end
        e[iso_pkg::OUT_RDY] = s >= iso_pkg::SOC_READY;
        e[iso_pkg::OUT_DIS +: 4] = c[3:0];
        e[iso_pkg::OUT_TEMP] = c[iso_pkg::COND_HOT];
        return e;
    endfunction

    task automatic plant(input logic [15:0] r, input logic [9:0] s, input logic [4:0] c, input logic en);
        logic [16:0] e;
        e = en ? exp_relay(r, s, c) : 17'h00000;
        axi_wr(iso_pkg::ADDR_RPM, {16'h0000, r}, iso_pkg::RESP_OKAY);
        axi_wr(iso_pkg::ADDR_SOC, {22'h000000, s}, iso_pkg::RESP_OKAY);
        axi_wr(iso_pkg::ADDR_COND, {27'h0000000, c}, iso_pkg::RESP_OKAY);
        axi_rd(iso_pkg::ADDR_RELAY, {15'h0000, e}, iso_pkg::RESP_OKAY);
        check({15'h0000, relay_o}, {15'h0000, e});
        check({15'h0000, led_out_o}, {15'h0000, e});
        check({31'h0, charge_inhibit_o}, {31'h0, c[iso_pkg::COND_HOT]});
    endtask

    task automatic cmd_try(input logic [2:0] m, input int n, input int es, input int eh, input int ec);
        u_far.press(m, n);
        repeat (4) @(posedge ref_clk);
        check(n_start, es);
        check(n_shd, eh);
        check(n_clr, ec);
    endtask

    always @(posedge ref_clk) begin
        cmd_d <= cmd_in;
        n_start <= n_start + (cmd_start_o === 1'b1);
        n_shd <= n_shd + (cmd_shutdown_o === 1'b1);
        n_clr <= n_clr + (cmd_clear_o === 1'b1);
        if (s_axi_rvalid && s_axi_rready) begin
            check(s_axi_rdata, exp_data_q.pop_front());
            check({30'h0, s_axi_rresp}, {30'h0, exp_resp_q.pop_front()});
        end
        if (led_chk && !reset) begin
            check({29'h0, led_in_o}, {29'h0, cmd_d});
        end
    end

    initial begin
        repeat (50000) @(posedge ref_clk);
        mismatches++;
        end_of_test();
    end

    initial begin
        reset = 1'b1;
        detect_strap = 1'b1;
        resp_fault = 1'b0;
        led_chk = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_wdata = 32'h00000000;
        s_axi_wstrb = 4'hf;
        {mismatches, tests_run, n_start, n_shd, n_clr} = '0;
        void'($urandom(32'h879a2d4c));
        do_reset();
        axi_rd(iso_pkg::ADDR_BOARD, 32'h00000021, iso_pkg::RESP_OKAY);
        check({31'h0, local_panel_en_o}, 32'h00000000);
        for (int i = 0; i < 6; i++) begin
            plant(t_rpm[i], t_soc[i], t_cond[i], 1'b1);
        end
        for (int i = 0; i < 6; i++) begin
            plant(16'($urandom_range(30000, 0)), 10'($urandom_range(1000, 0)), 5'($urandom), 1'b1);
        end
        led_chk <= 1'b1;
        cmd_try(3'h1, 12, 1, 0, 0);
        cmd_try(3'h2, 12, 1, 1, 0);
        cmd_try(3'h4, 12, 1, 1, 1);
        axi_rd(iso_pkg::ADDR_CMD, 32'h00000007, iso_pkg::RESP_OKAY);
        axi_wr(iso_pkg::ADDR_CMD, 32'h00000007, iso_pkg::RESP_OKAY);
        axi_rd(iso_pkg::ADDR_CMD, 32'h00000000, iso_pkg::RESP_OKAY);
        cmd_try(3'h1, HOLD - 1, 1, 1, 1);
        cmd_try(3'h3, 12, 1, 1, 1);
        led_chk <= 1'b0;
        resp_fault <= 1'b1;
        repeat (3) @(posedge ref_clk);
        check({31'h0, board_warn_o}, 32'h00000001);
        check({30'h0, board_state_o}, {30'h0, iso_pkg::BOARD_UNAVAILABLE_CODE});
        resp_fault <= 1'b0;
        repeat (3) @(posedge ref_clk);
        check({31'h0, board_warn_o}, 32'h00000000);
        axi_wr(iso_pkg::ADDR_BOARD, 32'h00000000, iso_pkg::RESP_OKAY);
        axi_rd(iso_pkg::ADDR_BOARD, 32'h00000030, iso_pkg::RESP_OKAY);
        plant(16'h7530, 10'h3e8, 5'h1f, 1'b0);
        cmd_try(3'h1, 12, 1, 1, 1);
        axi_wr(iso_pkg::ADDR_BOARD, 32'h00000001, iso_pkg::RESP_OKAY);
        axi_rd(iso_pkg::ADDR_BOARD, 32'h00000021, iso_pkg::RESP_OKAY);
        // strap low at the second reset must leave the board disabled
        detect_strap <= 1'b0;
        do_reset();
        axi_rd(iso_pkg::ADDR_BOARD, 32'h00000010, iso_pkg::RESP_OKAY);
        plant(16'h7530, 10'h3e8, 5'h00, 1'b0);
        axi_wr(8'h18, 32'h00000001, iso_pkg::RESP_SLVERR);
        axi_rd(8'h18, 32'h00000000, iso_pkg::RESP_SLVERR);
        s_axi_wstrb <= 4'h1;
        axi_wr(iso_pkg::ADDR_RPM, 32'h0000ffff, iso_pkg::RESP_OKAY);
        s_axi_wstrb <= 4'hf;
        axi_rd(iso_pkg::ADDR_RPM, 32'h000075ff, iso_pkg::RESP_OKAY);
        end_of_test();
    end
endmodule
